// ==== rtl/ser_result_regs.sv ====
// encoder result words: link capture, layout formatting and register port
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps

// ========================================================
// Overview of operation
// - both result words are read-only
// - command protocol low word is position 31:0
// - bidirectional protocol low word is position 31:0
// - motor low word: multi-turn 9 bits, single-turn 23
// - motor high word bits 6:0 upper multi-turn
// - high bit 31 flags reception timeout
// - single-frame layouts: bit 30 flags CRC failure
// - bidirectional: bits 29:24 hold encoder status
// - bidirectional: bits 7:0 upper position, 23:8 reserved
// - command protocol layout follows configured command code
// - position commands: error bit 29, position 7:0
// - two-frame commands: bit 30 position frame CRC
// - two-frame: bit 29 additional frame CRC
// - two-frame: error bits 27 and 26
// - two-frame: warning, reference mark, busy bits 23:21
// - two-frame: bits 20:16 echo range select code
// - two-frame: bits 15:0 additional data word
module ser_result_regs #(
	parameter int TIMEOUT_CYCLES = ser_pkg::TIMEOUT_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// encoder link pins
	input wire logic i_link_clk,
	input wire logic i_link_data,
	input wire logic i_link_frame,
	// register port
	input wire ser_pkg::ser_bus_req_t i_bus,
	output logic [31:0] o_rdata,
	// reception status
	output logic o_frame_done,
	output logic o_busy
);
	import ser_pkg::*;

	// the idle counter is 16 bits wide and the bit counter 8 bits wide
	if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin : g_bad_timeout
		$error("TIMEOUT_CYCLES out of range");
	end
	if (REC_W > 255) begin : g_bad_record
		$error("record longer than the bit counter can count");
	end

	localparam logic [15:0] TO_LAST = 16'(TIMEOUT_CYCLES - 1);
	localparam logic [7:0] REC_LEN = 8'(REC_W);

	// ========================================================
	// layout functions
	function automatic logic is_two_frame(input logic [5:0] cmd);
		is_two_frame = (cmd == CMD_ADD_A) || (cmd == CMD_ADD_B);
	endfunction : is_two_frame

	function automatic logic [31:0] low_word(input logic [1:0] proto, input ser_rec_t r);
		logic [15:0] mt;
		mt = r.pos[38:23];
		if (proto == PROTO_MOTOR) begin
			low_word = '0;
			low_word[31:LO_MT_LSB] = mt[8:0];
			low_word[ST_W-1:0] = r.pos[ST_W-1:0];
		end else begin
			low_word = r.pos[31:0];
		end
	endfunction : low_word

	function automatic logic [31:0] high_word(
		input logic [1:0] proto,
		input logic [5:0] cmd,
		input logic timeout,
		input ser_rec_t r
	);
		logic [15:0] mt;
		mt = r.pos[38:23];
		high_word = '0;
		high_word[HI_TO_BIT] = timeout;
		high_word[HI_CRC_BIT] = r.crc_fail_p;
		case (proto)
			PROTO_CMD: begin
				if (is_two_frame(cmd)) begin
					high_word[HI_CRC1_BIT] = r.crc_fail_1;
					high_word[HI_ERR1_BIT] = r.err1;
					high_word[HI_ERR2_BIT] = r.err2;
					high_word[HI_WRN_BIT] = r.encoder_warning_flag;
					high_word[HI_RM_BIT] = r.rm;
					high_word[HI_BUSY_BIT] = r.busy;
					high_word[HI_MRS_LSB +: 5] = r.memory_range_select;
					high_word[15:0] = r.add;
				end else begin
					high_word[HI_ERR_BIT] = r.err1;
					high_word[HI_POS_LSB +: 8] = r.pos[39:32];
				end
			end
			PROTO_MOTOR: begin
				high_word[6:0] = mt[15:9];
			end
			default: begin
				high_word[HI_STAT_LSB +: 6] = r.status;
				high_word[HI_POS_LSB +: 8] = r.pos[39:32];
			end
		endcase
	endfunction : high_word

	// ========================================================
	// pin synchronisers
	logic [2:0] pin_lvl;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	// clock, data and frame pass the same two flops, so they stay aligned
	ser_sync_edge #(
		.W(3)
	) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_async({i_link_frame, i_link_data, i_link_clk}),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	logic lk_rise;
	logic lk_data;
	logic fr_level;
	logic fr_rise;
	logic fr_fall;

	assign lk_rise = pin_rise[0];
	assign lk_data = pin_lvl[1];
	assign fr_level = pin_lvl[2];
	assign fr_rise = pin_rise[2];
	assign fr_fall = pin_fall[2];

	// ========================================================
	// control registers
	logic [1:0] proto_q;
	logic [1:0] proto_d;
	logic [5:0] cmd_q;
	logic [5:0] cmd_d;
	logic ctrl_wr;

	// result and status words ignore writes
	assign ctrl_wr = i_bus.wr && (i_bus.addr == OFF_CTRL);

	always_comb begin
		proto_d = proto_q;
		cmd_d = cmd_q;
		if (ctrl_wr) begin
			proto_d = i_bus.wdata[CTRL_PROTO_LSB +: 2];
			cmd_d = i_bus.wdata[CTRL_CMD_LSB +: 6];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			proto_q <= PROTO_RST;
			cmd_q <= CMD_RST;
		end else begin
			proto_q <= proto_d;
			cmd_q <= cmd_d;
		end
	end

	// ========================================================
	// reception
	// record arrives msb first; a short frame lands right-aligned, so the
	// crc flags are the last bits received unless the frame runs past the record
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RECV,
		ST_ABORT
	} ser_state_t;

	ser_state_t state_q;
	ser_state_t state_d;
	ser_rec_t rec_q;
	ser_rec_t rec_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [15:0] idle_q;
	logic [15:0] idle_d;
	logic [31:0] lo_q;
	logic [31:0] lo_d;
	logic [31:0] hi_q;
	logic [31:0] hi_d;
	logic [7:0] frames_q;
	logic [7:0] frames_d;
	logic [7:0] len_q;
	logic [7:0] len_d;
	logic done_q;
	logic done_d;
	logic busy_q;
	logic busy_d;

	always_comb begin
		state_d = state_q;
		rec_d = rec_q;
		cnt_d = cnt_q;
		idle_d = idle_q;
		lo_d = lo_q;
		hi_d = hi_q;
		frames_d = frames_q;
		len_d = len_q;
		done_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (fr_rise) begin
					state_d = ST_RECV;
					rec_d = '0;
					cnt_d = '0;
					idle_d = '0;
				end
			end
			ST_RECV: begin
				if (fr_fall) begin
					// both words and their flags change in one cycle
					lo_d = low_word(proto_q, rec_q);
					hi_d = high_word(proto_q, cmd_q, 1'b0, rec_q);
					len_d = cnt_q;
					frames_d = frames_q + 8'h01;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end else if (lk_rise) begin
					// bits beyond the record are dropped, count saturates
					if (cnt_q < REC_LEN) begin
						rec_d = ser_rec_t'({rec_q[REC_W-2:0], lk_data});
					end
					if (cnt_q != 8'hff) begin
						cnt_d = cnt_q + 8'h01;
					end
					idle_d = '0;
				end else if (idle_q == TO_LAST) begin
					// stalled link: data fields cleared, only the flag stands
					lo_d = '0;
					hi_d = high_word(proto_q, cmd_q, 1'b1, '0);
					len_d = cnt_q;
					frames_d = frames_q + 8'h01;
					done_d = 1'b1;
					state_d = ST_ABORT;
				end else begin
					idle_d = idle_q + 16'h0001;
				end
			end
			ST_ABORT: begin
				// wait for the frame to close before accepting a new one
				if (!fr_level) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			rec_q <= '0;
			cnt_q <= '0;
			idle_q <= '0;
			lo_q <= '0;
			hi_q <= '0;
			frames_q <= '0;
			len_q <= '0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rec_q <= rec_d;
			cnt_q <= cnt_d;
			idle_q <= idle_d;
			lo_q <= lo_d;
			hi_q <= hi_d;
			frames_q <= frames_d;
			len_q <= len_d;
			done_q <= done_d;
			busy_q <= busy_d;
		end
	end

	// ========================================================
	// register port
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] stat_word;
	logic [31:0] ctrl_word;

	always_comb begin
		stat_word = '0;
		stat_word[STAT_READY_BIT] = ~busy_q;
		stat_word[STAT_FRAMES_LSB +: 8] = frames_q;
		stat_word[STAT_LEN_LSB +: 8] = len_q;
		ctrl_word = '0;
		ctrl_word[CTRL_PROTO_LSB +: 2] = proto_q;
		ctrl_word[CTRL_CMD_LSB +: 6] = cmd_q;
	end

	// map: 0x00 low word, 0x04 high word, 0x08 control, 0x0c status
	// a read in the update cycle returns the previous frame's word; a reader
	// that wants both words of one frame reads them while the link is quiet
	always_comb begin
		rdata_d = '0;
		if (i_bus.rd) begin
			case (i_bus.addr)
				OFF_RES_LOW: begin
					rdata_d = lo_q;
				end
				OFF_RES_HIGH: begin
					rdata_d = hi_q;
				end
				OFF_CTRL: begin
					rdata_d = ctrl_word;
				end
				OFF_STATUS: begin
					rdata_d = stat_word;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_frame_done = done_q;
	assign o_busy = busy_q;

endmodule : ser_result_regs

// ==== common/ser_pkg.sv ====
// shared constants, types and field layouts for the encoder result registers
package ser_pkg;

	// ========================================================
	// register bus
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_RES_LOW = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_RES_HIGH = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} ser_bus_req_t;

	// ========================================================
	// control register fields and reset values
	localparam int CTRL_PROTO_LSB = 0;
	localparam int CTRL_CMD_LSB = 8;
	localparam logic [1:0] PROTO_RST = 2'h0;
	localparam logic [5:0] CMD_RST = 6'h07;

	// protocol select codes
	localparam logic [1:0] PROTO_BIDIR = 2'h0;
	localparam logic [1:0] PROTO_CMD = 2'h1;
	localparam logic [1:0] PROTO_MOTOR = 2'h2;

	// command codes of the command-driven protocol
	localparam logic [5:0] CMD_POS_A = 6'h07;
	localparam logic [5:0] CMD_POS_B = 6'h2a;
	localparam logic [5:0] CMD_ADD_A = 6'h38;
	localparam logic [5:0] CMD_ADD_B = 6'h2d;

	// status register fields
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_FRAMES_LSB = 8;
	localparam int STAT_LEN_LSB = 16;

	// ========================================================
	// high and low result word field positions
	localparam int HI_TO_BIT = 31;
	localparam int HI_CRC_BIT = 30;
	localparam int HI_CRC1_BIT = 29;
	localparam int HI_ERR_BIT = 29;
	localparam int HI_ERR1_BIT = 27;
	localparam int HI_ERR2_BIT = 26;
	localparam int HI_WRN_BIT = 23;
	localparam int HI_RM_BIT = 22;
	localparam int HI_BUSY_BIT = 21;
	localparam int HI_STAT_LSB = 24;
	localparam int HI_MRS_LSB = 16;
	localparam int HI_POS_LSB = 0;
	localparam int LO_MT_LSB = 23;
	localparam int ST_W = 23;

	// ========================================================
	// record shifted in from the link, first member first
	typedef struct packed {
		logic [39:0] pos;
		logic [5:0] status;
		logic err1;
		logic err2;
		logic encoder_warning_flag;
		logic rm;
		logic busy;
		logic [4:0] memory_range_select;
		logic [15:0] add;
		logic crc_fail_p;
		logic crc_fail_1;
	} ser_rec_t;

	localparam int REC_W = $bits(ser_rec_t);

	// ========================================================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int TIMEOUT_NS = 2000;
	localparam int TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ) / 1000;

endpackage : ser_pkg

// ==== rtl/ser_sync_edge.sv ====
// two-flop synchroniser with edge detection for link pins
`timescale 1ns/1ps
module ser_sync_edge #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// asynchronous pins
	input wire logic [W-1:0] i_async,
	// synchronised level and edges
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// meta_q is read only by sync_q
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign o_level = sync_q;
	assign o_rise = sync_q & ~prev_q;
	assign o_fall = ~sync_q & prev_q;

endmodule : ser_sync_edge

// ==== verif/ser_result_regs_assertions.sv ====
// checker for the encoder result word block
`timescale 1ns/1ps
module ser_chk #(
	parameter int TIMEOUT_CYCLES = 20
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// link pins
	input wire logic i_link_clk,
	input wire logic i_link_data,
	input wire logic i_link_frame,
	// register port
	input wire ser_pkg::ser_bus_req_t i_bus,
	input wire logic [31:0] o_rdata,
	// status
	input wire logic o_frame_done,
	input wire logic o_busy
);
	import ser_pkg::*;
	// ==========
	// cycles with the link clock frozen in a frame
	logic lclk_q;
	logic lclk_d;
	logic hold_q;
	logic hold_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	always_comb begin
		lclk_d = i_link_clk;
		hold_d = o_frame_done | (o_busy & hold_q);
		cnt_d = 16'h0;
		if (o_busy && i_link_frame && i_link_clk == lclk_q && !hold_q) begin
			cnt_d = cnt_q + 16'h1;
		end
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lclk_q <= 1'b0;
			hold_q <= 1'b0;
			cnt_q <= 16'h0;
		end else begin
			lclk_q <= lclk_d;
			hold_q <= hold_d;
			cnt_q <= cnt_d;
		end
	end
	// ==========
	// properties
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
		else $error("done pulse too long");
	done_busy_a: assert property (o_frame_done |-> $past(o_busy))
		else $error("done without reception");
	rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
		else $error("read data outside read slot");
	busy_start_a: assert property ($rose(i_link_frame) && !o_busy |-> ##[2:5] o_busy)
		else $error("frame start missed");
	to_late_a: assert property (cnt_q <= 16'(TIMEOUT_CYCLES + 6))
		else $error("timeout too late");
	to_early_a: assert property (o_frame_done && i_link_frame |-> cnt_q >= TIMEOUT_CYCLES - 8)
		else $error("timeout too early");
	busy_hold_a: assert property (o_busy && i_link_frame |=> o_busy)
		else $error("busy dropped inside frame");
	done_end_a: assert property ($fell(i_link_frame) && o_busy && !hold_q |-> ##[2:7] o_frame_done)
		else $error("no update after frame end");
endmodule : ser_chk

bind ser_result_regs ser_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_link_clk(i_link_clk), .i_link_data(i_link_data),
	.i_link_frame(i_link_frame), .i_bus(i_bus), .o_rdata(o_rdata),
	.o_frame_done(o_frame_done), .o_busy(o_busy)
);

// ==== verif/ser_enc_model.sv ====
// model of the absolute encoder on the serial link
`timescale 1ns/1ps
module ser_enc_model (
	// link pins
	output logic o_link_clk,
	output logic o_link_data,
	output logic o_link_frame
);
	import ser_pkg::*;
	initial begin
		o_link_clk = 1'b0;
		o_link_data = 1'b0;
		o_link_frame = 1'b0;
	end
	// msb first; a stall keeps the frame open with the clock frozen
	task automatic send(input ser_rec_t r, input int n, input int stall);
		// keep pin changes off the block's sampling edge
		#1;
		o_link_frame = 1'b1;
		#48;
		for (int i = n - 1; i >= 0; i--) begin
			o_link_data = r[i];
			#24 o_link_clk = 1'b1;
			#24 o_link_clk = 1'b0;
		end
		#(stall + 48);
		o_link_frame = 1'b0;
		// released line must not keep the last bit
		o_link_data = ~o_link_data;
	endtask : send
endmodule : ser_enc_model

// ==== verif/ser_result_regs_tb_top.sv ====
// self-checking bench for the encoder result word block
`timescale 1ns/1ps
module ser_result_regs_tb_top;
	import ser_pkg::*;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic lclk;
	logic ldat;
	logic lfrm;
	ser_bus_req_t bus = '0;
	logic [31:0] rdata;
	logic done;
	logic busy;
	ser_rec_t rec;
	int bad_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int nfr = 0;
	logic [31:0] last_rd = '0;
	always #2 i_clk = ~i_clk;
	ser_enc_model i_model (.o_link_clk(lclk), .o_link_data(ldat), .o_link_frame(lfrm));
	ser_result_regs #(.TIMEOUT_CYCLES(20)) i_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_link_clk(lclk), .i_link_data(ldat),
		.i_link_frame(lfrm), .i_bus(bus), .o_rdata(rdata), .o_frame_done(done), .o_busy(busy)
	);
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s: expected %h, seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge i_clk);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge i_clk);
		bus.rd <= 1'b0;
		#1;
		chk(n, e, rdata);
		last_rd = rdata;
	endtask : rd
	task automatic frame(input int n, input int stall);
		int k;
		k = 0;
		fork
			i_model.send(rec, n, stall);
		join_none
		while (done !== 1'b1 && k < 2000) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		chk("done pulse", 32'h1, {31'h0, done});
		// busy outlives the update only while a timed-out frame is still open
		chk("busy at update", {31'h0, lfrm}, {31'h0, busy});
		wait (lfrm === 1'b0);
		repeat (6) @(posedge i_clk);
		nfr++;
		#1;
		chk("busy after frame", 32'h0, {31'h0, busy});
		rd(OFF_STATUS, {8'h00, 8'(n), 8'(nfr), 8'h01}, "status");
	endtask : frame
	task automatic t_bidir();
		rd(OFF_CTRL, 32'h700, "ctrl reset");
		rd(8'hf0, 32'h0, "unmapped");
		rd(OFF_RES_HIGH, 32'h0, "high reset");
		rec = '{40'ha512345678, 6'h2b, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 5'h1f, 16'hffff, 1'b1, 1'b1};
		frame(74, 0);
		wr(OFF_RES_LOW, 32'h0);
		wr(OFF_RES_HIGH, 32'h0);
		rd(OFF_RES_LOW, 32'h12345678, "bidir low");
		rd(OFF_RES_HIGH, 32'h6b0000a5, "bidir high");
		// spare protocol code falls back to the bidirectional layout
		wr(OFF_CTRL, {18'h0, CMD_RST, 6'h0, 2'h3});
		wr(OFF_STATUS, 32'hffffffff);
		rd(OFF_CTRL, 32'h703, "ctrl spare code");
		frame(74, 0);
		rd(OFF_RES_HIGH, 32'h6b0000a5, "spare code high");
		$display("bidir layout test done");
	endtask : t_bidir
	task automatic t_cmd();
		logic [5:0] c [4] = '{CMD_POS_A, CMD_POS_B, CMD_ADD_A, CMD_ADD_B};
		logic [31:0] e [4] = '{32'h2000003c, 32'h2000003c, 32'h2cb5beef, 32'h2cb5beef};
		rec = '{40'h3c89abcdef, 6'h3f, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 5'h15, 16'hbeef, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CTRL, {18'h0, c[i], 6'h0, PROTO_CMD});
			frame(74, 0);
			rd(OFF_RES_LOW, 32'h89abcdef, "cmd low");
			rd(OFF_RES_HIGH, e[i], "cmd high");
			if (i >= 2) begin
				// the echo must match before the additional data is trusted
				chk("range select echo", {27'h0, rec.memory_range_select}, {27'h0, last_rd[20:16]});
				chk("additional data", {16'h0, rec.add}, {16'h0, last_rd[15:0]});
			end
		end
		$display("command layout test done");
	endtask : t_cmd
	task automatic t_motor();
		wr(OFF_CTRL, {18'h0, CMD_RST, 6'h0, PROTO_MOTOR});
		// top position bit set so that high bit 7 must stay clear
		rec = '{40'hdac3a59669, 6'h3f, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 5'h1f, 16'hffff, 1'b1, 1'b1};
		frame(74, 0);
		rd(OFF_RES_LOW, 32'hc3a59669, "motor low");
		rd(OFF_RES_HIGH, 32'h4000005a, "motor high");
		$display("motor layout test done");
	endtask : t_motor
	task automatic t_reset();
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk("busy in reset", 32'h0, {31'h0, busy});
		chk("done in reset", 32'h0, {31'h0, done});
		@(posedge i_clk);
		i_nrst <= 1'b1;
		nfr = 0;
		rd(OFF_RES_LOW, 32'h0, "low after reset");
		rd(OFF_RES_HIGH, 32'h0, "high after reset");
		rd(OFF_CTRL, 32'h700, "ctrl after reset");
		rd(OFF_STATUS, 32'h1, "status after reset");
		$display("mid-run reset test done");
	endtask : t_reset
	task automatic t_timeout();
		wr(OFF_CTRL, {18'h0, CMD_RST, 6'h0, PROTO_BIDIR});
		// ten bits then a frozen clock well past the limit
		frame(10, 400);
		rd(OFF_RES_LOW, 32'h0, "timeout low");
		rd(OFF_RES_HIGH, 32'h80000000, "timeout high");
		$display("timeout test done");
	endtask : t_timeout
	initial begin
		repeat (10) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_bidir();
		t_cmd();
		t_motor();
		t_reset();
		t_timeout();
		give_verdict();
	end
	// a hang counts as a mismatch
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			give_verdict();
		end
	end
endmodule : ser_result_regs_tb_top
